//--- design/intc_defs.vh
// Summary of operation
// - Eight request inputs, each its own level
// - Chain controllers for up to 64 levels
// - Masked requests never reach the processor
// - Chain id lines: master drives, slave samples
// - Register access only with chip select low
// - Acknowledge pulses work without chip select
// - Eight-bit three-state data port
// - Interrupt high while eligible request pending
// - Each acknowledge pulse after the first returns next vector byte
// - Requests are asynchronous, sampled safely
// - Edge mode: rising edge, held until acknowledged or line drops
// - Level mode: high level alone requests
// - Read strobe drives selected status byte
// - Write strobe captures a command word
// - Port select bit splits words and sources
// - Buffered mode: pin enables bus transceivers
// - Otherwise pin strap: high master, low slave
// - Signal only if outranking every in-service
// - Hold routine address, supply for source
// - Call mode or vector mode, exclusive
// - Priority modes changeable by runtime words
// - First acknowledge: responding device sets service, clears edge-mode request
// - Call mode: low then high address byte
// - Vector mode: float first, vector second
// - Auto end clears at last acknowledge
`ifndef INTC_DEFS_VH
`define INTC_DEFS_VH

// Synchroniser bus width and idle levels
`define SYNC_WIDTH     25
`define SYNC_IDLE      25'h000_007c

// Call opcode for the first acknowledge byte
`define CALL_OPCODE    8'hcd

// Word discrimination bits on a port 0 write
`define INIT_FLAG_BIT  4
`define RT_SEL_BIT     3

// First init word fields
`define W1_NEED_W4     0
`define W1_SINGLE      1
`define W1_INTERVAL4   2
`define W1_LEVEL       3

// Fourth init word fields
`define W4_VECTOR      0
`define W4_AUTO_EOI    1
`define W4_BUF_MASTER  2
`define W4_BUFFERED    3

// Read select fields of the status select word
`define RS_VALID_BIT   1
`define RS_ISR_BIT     0

// Runtime command codes (end of service, rotation, priority), bits 7:5
`define CMD_ROT_AUTO_END_OF_SERVICE_CLR 3'h0
`define CMD_EOI_NONSPEC  3'h1
`define CMD_EOI_SPEC     3'h3
`define CMD_ROT_AUTO_END_OF_SERVICE_SET 3'h4
`define CMD_ROT_NONSPEC  3'h5
`define CMD_SET_PRIO     3'h6
`define CMD_ROT_SPEC     3'h7

// Reset values
`define LOWEST_RESET   3'h7
`define MASK_RESET     8'h00

`endif

//--- design/priority_interrupt_controller.v
`timescale 1ns/10ps
`include "intc_defs.vh"
module priority_interrupt_controller (
    input  wire       clk,
    input  wire       srst,
    input  wire [7:0] request_lines,
    input  wire       cs_n,
    input  wire       rd_n,
    input  wire       wr_n,
    input  wire       port_select_bit,
    input  wire       ack_pulse_in_n,
    input  wire [7:0] data_in,
    output reg  [7:0] data_out,
    output reg        data_oe,
    output reg        int_out,
    input  wire [2:0] chain_id_in,
    output reg  [2:0] chain_id_out,
    output reg        chain_id_oe,
    input  wire       master_slave_buf_pin_in,
    output wire       master_slave_buf_pin_out,
    output wire       master_slave_buf_pin_oe
);
    ////////////////////////////////////////////////////////////////
    // Programming states
    localparam [2:0] ST_IDLE = 3'h0;  // Not initialised
    localparam [2:0] ST_W2   = 3'h1;  // Waiting address word
    localparam [2:0] ST_W3   = 3'h2;  // Waiting chain word
    localparam [2:0] ST_W4   = 3'h3;  // Waiting mode word
    localparam [2:0] ST_RUN  = 3'h4;  // Operating

    ////////////////////////////////////////////////////////////////
    // Input synchronisation
    wire [`SYNC_WIDTH-1:0] sync_out;       // Settled pin copies
    wire [7:0]             req;            // Settled request lines
    wire [7:0]             din;            // Settled data bus
    wire [2:0]             chain_s;        // Settled chain id
    wire                   cs_s;           // Settled chip select, low active
    wire                   rd_s;           // Settled read, low active
    wire                   wr_s;           // Settled write, low active
    wire                   ack_s;          // Settled acknowledge, low active
    wire                   sel_s;          // Settled port select
    wire                   strap_s;        // Settled master strap

    // All pins cross into clk before any logic reads them
    sync_bank #(
        .WIDTH (`SYNC_WIDTH),
        .IDLE  (`SYNC_IDLE)
    ) u_sync (
        .clk  (clk),
        .srst (srst),
        .din  ({request_lines, data_in, chain_id_in, cs_n, rd_n, wr_n,
                ack_pulse_in_n, port_select_bit, master_slave_buf_pin_in}),
        .dout (sync_out)
    );
    assign {req, din, chain_s, cs_s, rd_s, wr_s, ack_s, sel_s, strap_s} = sync_out;

    ////////////////////////////////////////////////////////////////
    // Edge history
    reg [7:0] req_q;     // Previous request levels
    reg       wr_q;      // Previous write strobe
    reg       ack_q;     // Previous acknowledge strobe

    // Edges are taken from settled copies only
    always @(posedge clk) begin
        if (srst) begin
            req_q <= 8'h00;
            wr_q  <= 1'b1;
            ack_q <= 1'b1;
        end else begin
            req_q <= req;
            wr_q  <= wr_s;
            ack_q <= ack_s;
        end
    end

    wire wr_rise  = wr_s & ~wr_q & ~cs_s;
    wire ack_fall = ~ack_s & ack_q;
    wire ack_rise = ack_s & ~ack_q;
    wire rd_act   = ~rd_s & ~cs_s;
    wire port0    = ~sel_s;

    ////////////////////////////////////////////////////////////////
    // Programming registers
    reg [2:0] state;        // Programming state
    reg       need_w4;      // Mode word expected
    reg       single;       // No chained partners
    reg       interval4;    // Four-byte call spacing
    reg       level_mode;   // Level sensing
    reg [2:0] addr_lo;      // Call address bits 7:5
    reg [7:0] addr_hi;      // High address or vector base
    reg [7:0] chain_cfg;    // Master: slave map; slave: own id
    reg       vector_mode;  // One-byte vector operation
    reg       auto_eoi;     // Automatic end of service
    reg       buf_master;   // Master role in buffered mode
    reg       buf_mode;     // Pin drives transceivers
    reg [7:0] mask_latch;   // Per-source mask
    reg [2:0] lowest;       // Weakest level for rotation
    reg       rot_auto_end_of_service;     // Rotate on automatic end
    reg       read_isr;     // Status read selects service latch

    // Role follows strap unless buffered mode fixes it
    wire master = buf_mode ? buf_master : strap_s;

    ////////////////////////////////////////////////////////////////
    // Priority resolution
    reg  [7:0] request_latch;   // Pending requests
    reg  [7:0] service_latch;   // Levels in service
    wire       pend_found;      // Some unmasked request
    wire [2:0] pend_level;      // Strongest unmasked request
    wire [2:0] pend_rank;       // Its rank, 0 strongest
    wire       isr_found;       // Some level in service
    wire [2:0] isr_level;       // Strongest in service
    wire [2:0] isr_rank;        // Its rank

    // Masked sources are removed before ranking
    priority_pick u_pend (
        .vec    (request_latch & ~mask_latch),
        .lowest (lowest),
        .found  (pend_found),
        .level  (pend_level),
        .rank   (pend_rank)
    );

    // Strongest level already being serviced
    priority_pick u_isr (
        .vec    (service_latch),
        .lowest (lowest),
        .found  (isr_found),
        .level  (isr_level),
        .rank   (isr_rank)
    );

    ////////////////////////////////////////////////////////////////
    // Acknowledge sequence
    reg  [1:0] ack_cnt;     // Pulses done in this sequence
    reg  [2:0] sel_level;   // Level frozen at first pulse
    reg        sel_valid;   // A request was frozen
    reg        hit;         // This device answers the sequence
    wire [1:0] last_cnt = vector_mode ? 2'h1 : 2'h2;
    wire       slave_map = chain_cfg[sel_level];

    // Does this device supply the routine address bytes
    wire responder = single | (master & ~slave_map) |
                     (~master & (chain_s == chain_cfg[2:0]));

    // Byte for the current pulse
    reg       drive_ack;
    reg [7:0] ack_byte;
    always @* begin
        drive_ack = 1'b0;
        ack_byte  = 8'h00;
        case (ack_cnt)
            2'h0: begin
                // Call opcode from master or lone device; vector floats
                drive_ack = ~vector_mode & (single | master);
                ack_byte  = `CALL_OPCODE;
            end
            2'h1: begin
                drive_ack = hit;
                if (vector_mode) begin
                    ack_byte = {addr_hi[7:3], sel_level};
                end else if (interval4) begin
                    ack_byte = {addr_lo, sel_level, 2'b00};
                end else begin
                    ack_byte = {addr_lo[2:1], sel_level, 3'b000};
                end
            end
            2'h2: begin
                drive_ack = hit & ~vector_mode;
                ack_byte  = addr_hi;
            end
            default: begin
                drive_ack = 1'b0;
                ack_byte  = 8'h00;
            end
        endcase
    end

    // Pulse counting and level freeze
    always @(posedge clk) begin
        if (srst) begin
            ack_cnt   <= 2'h0;
            sel_level <= 3'h7;
            sel_valid <= 1'b0;
            hit       <= 1'b0;
        end else begin
            if (ack_fall && ack_cnt == 2'h0) begin
                // Spurious sequences report level 7
                sel_level <= pend_found ? pend_level : 3'h7;
                sel_valid <= pend_found;
            end
            if (ack_rise) begin
                if (ack_cnt == 2'h0) begin
                    hit <= responder;
                end
                if (ack_cnt == last_cnt) begin
                    ack_cnt <= 2'h0;
                end else begin
                    ack_cnt <= ack_cnt + 2'h1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // Runtime command decode
    wire       is_w1  = wr_rise & port0 & din[`INIT_FLAG_BIT];
    wire       is_cmd = wr_rise & port0 & ~din[`INIT_FLAG_BIT] & ~din[`RT_SEL_BIT];
    wire       is_rs  = wr_rise & port0 & ~din[`INIT_FLAG_BIT] & din[`RT_SEL_BIT];
    wire [2:0] cmd    = din[7:5];
    wire       first_done = ack_rise & (ack_cnt == 2'h0) & sel_valid & responder;
    wire       last_done  = ack_rise & (ack_cnt == last_cnt) & auto_eoi & hit;
    reg  [7:0] isr_clr;      // Levels leaving service
    reg  [7:0] isr_set;      // Level entering service

    // Set and clear masks for the service latch
    always @* begin
        isr_set = 8'h00;
        isr_clr = 8'h00;
        if (first_done) begin
            isr_set[sel_level] = 1'b1;
        end
        if (last_done) begin
            isr_clr[sel_level] = 1'b1;
        end
        if (is_cmd) begin
            case (cmd)
                `CMD_EOI_NONSPEC, `CMD_ROT_NONSPEC: begin
                    if (isr_found) begin
                        isr_clr[isr_level] = 1'b1;
                    end
                end
                `CMD_EOI_SPEC, `CMD_ROT_SPEC: begin
                    isr_clr[din[2:0]] = 1'b1;
                end
                default: begin
                    // Other codes leave the service latch alone
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////
    // Request and service latches; a set beats a clear
    integer b;
    always @(posedge clk) begin
        if (srst) begin
            request_latch <= 8'h00;
            service_latch <= 8'h00;
        end else begin
            service_latch <= (service_latch & ~isr_clr) | isr_set;
            for (b = 0; b < 8; b = b + 1) begin
                if (level_mode) begin
                    request_latch[b] <= req[b];
                end else if (req[b] & ~req_q[b]) begin
                    request_latch[b] <= 1'b1;
                end else if (isr_set[b] | ~req[b]) begin
                    // Dropping the line early withdraws the request
                    request_latch[b] <= 1'b0;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // Command words and programming sequence
    always @(posedge clk) begin
        if (srst) begin
            state       <= ST_IDLE;
            need_w4     <= 1'b0;
            single      <= 1'b1;
            interval4   <= 1'b0;
            level_mode  <= 1'b0;
            addr_lo     <= 3'h0;
            addr_hi     <= 8'h00;
            chain_cfg   <= 8'h00;
            vector_mode <= 1'b0;
            auto_eoi    <= 1'b0;
            buf_master  <= 1'b0;
            buf_mode    <= 1'b0;
            mask_latch  <= `MASK_RESET;
            lowest      <= `LOWEST_RESET;
            rot_auto_end_of_service    <= 1'b0;
            read_isr    <= 1'b0;
        end else begin
            if (is_w1) begin
                // Restart programming; defaults to call mode
                state       <= ST_W2;
                need_w4     <= din[`W1_NEED_W4];
                single      <= din[`W1_SINGLE];
                interval4   <= din[`W1_INTERVAL4];
                level_mode  <= din[`W1_LEVEL];
                addr_lo     <= din[7:5];
                vector_mode <= 1'b0;
                auto_eoi    <= 1'b0;
                buf_mode    <= 1'b0;
                mask_latch  <= `MASK_RESET;
                lowest      <= `LOWEST_RESET;
                rot_auto_end_of_service    <= 1'b0;
                read_isr    <= 1'b0;
            end else if (wr_rise && sel_s) begin
                // Port 1 words depend on sequence position
                case (state)
                    ST_W2: begin
                        addr_hi <= din;
                        state   <= ~single ? ST_W3 : (need_w4 ? ST_W4 : ST_RUN);
                    end
                    ST_W3: begin
                        chain_cfg <= din;
                        state     <= need_w4 ? ST_W4 : ST_RUN;
                    end
                    ST_W4: begin
                        vector_mode <= din[`W4_VECTOR];
                        auto_eoi    <= din[`W4_AUTO_EOI];
                        buf_master  <= din[`W4_BUF_MASTER];
                        buf_mode    <= din[`W4_BUFFERED];
                        state       <= ST_RUN;
                    end
                    ST_RUN: begin
                        mask_latch <= din;
                    end
                    default: begin
                        state <= ST_IDLE;
                    end
                endcase
            end else if (is_cmd) begin
                // Rotation and priority changes at any time
                case (cmd)
                    `CMD_ROT_AUTO_END_OF_SERVICE_CLR: rot_auto_end_of_service <= 1'b0;
                    `CMD_ROT_AUTO_END_OF_SERVICE_SET: rot_auto_end_of_service <= 1'b1;
                    `CMD_ROT_NONSPEC: begin
                        if (isr_found) begin
                            lowest <= isr_level;
                        end
                    end
                    `CMD_ROT_SPEC, `CMD_SET_PRIO: lowest <= din[2:0];
                    default: lowest <= lowest;
                endcase
            end else if (is_rs) begin
                if (din[`RS_VALID_BIT]) begin
                    read_isr <= din[`RS_ISR_BIT];
                end
            end else if (last_done && rot_auto_end_of_service) begin
                lowest <= sel_level;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // Outputs: interrupt, data port, chain id
    always @(posedge clk) begin
        if (srst) begin
            int_out      <= 1'b0;
            data_out     <= 8'h00;
            data_oe      <= 1'b0;
            chain_id_out <= 3'h0;
            chain_id_oe  <= 1'b0;
        end else begin
            // Only a request outranking all in-service levels
            int_out <= (state == ST_RUN) & pend_found &
                       (~isr_found | (pend_rank < isr_rank));
            if (~ack_s && drive_ack) begin
                data_out <= ack_byte;
                data_oe  <= 1'b1;
            end else if (rd_act) begin
                // Status source by port and read select
                data_out <= sel_s ? mask_latch :
                            (read_isr ? service_latch : request_latch);
                data_oe  <= 1'b1;
            end else begin
                data_oe  <= 1'b0;
            end
            // Master names the slave while the sequence runs
            chain_id_out <= sel_level;
            chain_id_oe  <= master & ~single & (~ack_s | ack_cnt != 2'h0);
        end
    end

    // Buffered mode turns the strap pin into a transceiver enable
    assign master_slave_buf_pin_oe  = buf_mode;
    assign master_slave_buf_pin_out = ~data_oe;

endmodule // priority_interrupt_controller

//--- design/priority_pick.v
`timescale 1ns/10ps
// Rotating priority finder: level after 'lowest' ranks first
module priority_pick (
    input  wire [7:0] vec,
    input  wire [2:0] lowest,
    output reg        found,
    output reg  [2:0] level,
    output reg  [2:0] rank
);
    integer   i;
    reg [2:0] cand;
    // Scan from weakest to strongest so the strongest wins
    always @* begin
        found = 1'b0;
        level = 3'h0;
        rank  = 3'h7;
        cand  = 3'h0;
        for (i = 7; i >= 0; i = i - 1) begin
            cand = lowest + 3'h1 + i[2:0];
            if (vec[cand]) begin
                found = 1'b1;
                level = cand;
                rank  = i[2:0];
            end
        end
    end
endmodule // priority_pick

//--- design/sync_bank.v
`timescale 1ns/10ps
// Two-flop synchroniser per bit; idle value loaded by reset
module sync_bank #(
    parameter WIDTH = 8,
    parameter [WIDTH-1:0] IDLE = {WIDTH{1'b0}}
) (
    input  wire             clk,
    input  wire             srst,
    input  wire [WIDTH-1:0] din,
    output wire [WIDTH-1:0] dout
);
    reg [WIDTH-1:0] stage1;   // Metastable stage, read only by stage2
    reg [WIDTH-1:0] stage2;   // Settled copy
    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            // One flop pair per bit
            always @(posedge clk) begin
                if (srst) begin
                    stage1[i] <= IDLE[i];
                    stage2[i] <= IDLE[i];
                end else begin
                    stage1[i] <= din[i];
                    stage2[i] <= stage1[i];
                end
            end
        end
    endgenerate
    assign dout = stage2;
endmodule // sync_bank

//--- testbench/pic_host_model.sv
`timescale 1ns/10ps
////////////////////////////////////////
// Host side of the shared pins
module pic_host_model (
    input  wire       clk,
    input  wire [7:0] dev_data,
    input  wire       dev_oe,
    input  wire [7:0] host_data,
    input  wire       host_oe,
    input  wire       strap,
    input  wire       pin_out,
    input  wire       pin_oe,
    output wire [7:0] bus,
    output wire       pin_level
);
    reg [7:0] last = 8'h00; // Last bus level
    // Released bus toggles so stale data never looks valid
    assign bus = host_oe ? host_data : (dev_oe ? dev_data : ~last);
    // Strap wins only while the device does not drive the pin
    assign pin_level = pin_oe ? pin_out : strap;
    always @(posedge clk) begin
        last <= bus;
    end
endmodule // pic_host_model

//--- testbench/priority_interrupt_controller_sva.sv
`timescale 1ns/10ps
////////////////////////////////////////
module pic_checker (
    input wire       clk,
    input wire       srst,
    input wire [7:0] request_lines,
    input wire       cs_n,
    input wire       rd_n,
    input wire       wr_n,
    input wire       ack_pulse_in_n,
    input wire       data_oe,
    input wire       int_out,
    input wire       chain_id_oe,
    input wire       master_slave_buf_pin_in,
    input wire       master_slave_buf_pin_out,
    input wire       master_slave_buf_pin_oe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    // Read held past the synchroniser lag
    sequence rd_held;
        (!cs_n && !rd_n && ack_pulse_in_n)[*5];
    endsequence
    // No read and no acknowledge for a while
    sequence bus_idle;
        ((cs_n || rd_n) && ack_pulse_in_n)[*5];
    endsequence
    rst_quiet_a: assert property (disable iff (1'b0) srst |=> !int_out && !data_oe && !chain_id_oe)
        else $error("outputs active after reset");
    rd_answer_a: assert property (rd_held |-> data_oe)
        else $error("read not answered");
    bus_float_a: assert property (bus_idle |-> !data_oe)
        else $error("bus driven while idle");
    rd_release_a: assert property ($rose(rd_n) && ack_pulse_in_n |-> ##[1:5] !data_oe)
        else $error("bus not released after read");
    wr_silent_a: assert property ((!wr_n && rd_n && ack_pulse_in_n)[*4] |-> !data_oe)
        else $error("bus driven during write");
    no_req_int_a: assert property ((request_lines == 8'h00)[*8] |-> !int_out)
        else $error("interrupt without request");
    xcvr_en_a: assert property (master_slave_buf_pin_oe |-> master_slave_buf_pin_out == !data_oe)
        else $error("transceiver enable wrong");
    chain_drv_a: assert property (chain_id_oe |-> master_slave_buf_pin_oe || master_slave_buf_pin_in)
        else $error("slave drives chain id");
endmodule // pic_checker
bind priority_interrupt_controller pic_checker pic_checker_i (.clk(clk), .srst(srst),
    .request_lines(request_lines), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .ack_pulse_in_n(ack_pulse_in_n),
    .data_oe(data_oe), .int_out(int_out), .chain_id_oe(chain_id_oe),
    .master_slave_buf_pin_in(master_slave_buf_pin_in), .master_slave_buf_pin_out(master_slave_buf_pin_out),
    .master_slave_buf_pin_oe(master_slave_buf_pin_oe));

//--- testbench/tb_priority_interrupt_controller.sv
`timescale 1ns/10ps
////////////////////////////////////////
module tb_priority_interrupt_controller;
    reg        clk = 1'b0;
    reg        srst = 1'b1;
    reg  [7:0] request_lines = 8'h00;
    reg        cs_n = 1'b1;
    reg        rd_n = 1'b1;
    reg        wr_n = 1'b1;
    reg        psel = 1'b0;
    reg        ack_n = 1'b1;
    reg  [7:0] host_data = 8'h00;
    reg        host_oe = 1'b0;
    reg        strap = 1'b1;        // Strapped as master
    wire [7:0] bus;
    wire [7:0] data_out;
    wire [2:0] chain_id;            // Looped back: single device
    wire       data_oe, int_out, chain_id_oe, pin_out, pin_oe, pin_level;
    integer    n_errors = 0;
    integer    checks_done = 0;
    integer    cycles = 0;
    always #5 clk = ~clk;
    priority_interrupt_controller priority_interrupt_controller_i (.clk(clk), .srst(srst),
        .request_lines(request_lines), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .port_select_bit(psel),
        .ack_pulse_in_n(ack_n), .data_in(bus), .data_out(data_out), .data_oe(data_oe), .int_out(int_out),
        .chain_id_in(chain_id), .chain_id_out(chain_id), .chain_id_oe(chain_id_oe),
        .master_slave_buf_pin_in(pin_level), .master_slave_buf_pin_out(pin_out), .master_slave_buf_pin_oe(pin_oe));
    pic_host_model pic_host_model_i (.clk(clk), .dev_data(data_out), .dev_oe(data_oe), .host_data(host_data),
        .host_oe(host_oe), .strap(strap), .pin_out(pin_out), .pin_oe(pin_oe), .bus(bus), .pin_level(pin_level));
    ////////////////////////////////////////
    task chk(input [8*10:1] nm, input [7:0] exp, input [7:0] got);
        begin
            checks_done = checks_done + 1;
            if (got !== exp) begin
                n_errors = n_errors + 1;
                $display("[ERR] %0s expected %h seen %h", nm, exp, got);
            end
        end
    endtask
    // Chip select outlasts the strobe so the word is taken
    task wr(input sel, input [7:0] val, input csn);
        begin
            @(negedge clk);
            psel = sel;
            host_data = val;
            host_oe = 1'b1;
            cs_n = csn;
            wr_n = 1'b0;
            repeat (5) @(negedge clk);
            wr_n = 1'b1;
            repeat (4) @(negedge clk);
            cs_n = 1'b1;
            host_oe = 1'b0;
            repeat (4) @(negedge clk);
        end
    endtask
    task rd(input sel, input [7:0] exp);
        begin
            @(negedge clk);
            psel = sel;
            cs_n = 1'b0;
            rd_n = 1'b0;
            repeat (5) @(negedge clk);
            chk("read_oe", 8'h01, {7'h00, data_oe});
            chk("read_data", exp, data_out);
            rd_n = 1'b1;
            cs_n = 1'b1;
            repeat (6) @(negedge clk);
        end
    endtask
    // Acknowledge with chip select left high
    task ack(input oe, input [7:0] d);
        begin
            @(negedge clk);
            ack_n = 1'b0;
            repeat (5) @(negedge clk);
            chk("ack_oe", {7'h00, oe}, {7'h00, data_oe});
            if (oe) chk("ack_byte", d, data_out);
            ack_n = 1'b1;
            repeat (6) @(negedge clk);
        end
    endtask
    task wait_int(input e);
        integer k;
        begin
            for (k = 0; k < 12 && int_out !== e; k = k + 1) @(negedge clk);
            chk("int_out", {7'h00, e}, {7'h00, int_out});
        end
    endtask
    ////////////////////////////////////////
    task t_reset;
        begin
            chk("int_out", 8'h00, {7'h00, int_out});
            chk("pin_out", 8'h01, {7'h00, pin_out});
            request_lines = 8'h08;
            repeat (10) @(negedge clk);
            chk("uninit", 8'h00, {7'h00, int_out});
            request_lines = 8'h00;
        end
    endtask
    // Vector mode, edge, cascade master; level 3 serviced
    task t_vector;
        begin
            wr(1'b0, 8'h11, 1'b0);
            wr(1'b1, 8'h40, 1'b0);
            wr(1'b1, 8'h00, 1'b0);
            wr(1'b1, 8'h01, 1'b0);
            request_lines = 8'h08;
            wait_int(1'b1);
            ack(1'b0, 8'h00);
            chk("chain_oe", 8'h01, {7'h00, chain_id_oe});
            chk("chain_id", 8'h03, {5'h00, chain_id});
            ack(1'b1, 8'h43);
            chk("chain_oe", 8'h00, {7'h00, chain_id_oe});
            wait_int(1'b0);
            wr(1'b0, 8'h0b, 1'b0);
            rd(1'b0, 8'h08);
            wr(1'b0, 8'h0a, 1'b0);
            rd(1'b0, 8'h00);
        end
    endtask
    // Lower level waits for end of service, then mask
    task t_nest;
        begin
            request_lines = 8'h28;
            repeat (12) @(negedge clk);
            chk("nested", 8'h00, {7'h00, int_out});
            wr(1'b0, 8'h20, 1'b0);
            wait_int(1'b1);
            wr(1'b1, 8'h20, 1'b0);
            wait_int(1'b0);
            rd(1'b1, 8'h20);
            wr(1'b1, 8'h40, 1'b1);
            rd(1'b1, 8'h20);
            request_lines = 8'h00;
        end
    endtask
    // Call mode, level, auto end, buffered
    task t_call;
        begin
            repeat (12) @(negedge clk);
            request_lines = 8'h40;
            wr(1'b0, 8'hbf, 1'b0);
            wr(1'b1, 8'h12, 1'b0);
            wr(1'b1, 8'h0e, 1'b0);
            chk("pin_oe", 8'h01, {7'h00, pin_oe});
            wait_int(1'b1);
            ack(1'b1, 8'hcd);
            ack(1'b1, 8'hb8);
            ack(1'b1, 8'h12);
            request_lines = 8'h00;
            wr(1'b0, 8'h0b, 1'b0);
            rd(1'b0, 8'h00);
        end
    endtask
    task finish_test;
        begin
            $display("checks %0d errors %0d", checks_done, n_errors);
            if (n_errors == 0 && checks_done > 0) begin
                $display("STATUS OK");
            end else begin
                $display("STATUS NOT OK");
            end
            $finish;
        end
    endtask
    ////////////////////////////////////////
    initial begin
        repeat (8) @(negedge clk);
        srst = 1'b0;
        t_reset;
        t_vector;
        t_nest;
        t_call;
        finish_test;
    end
    // Hang guard, well above the run length
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_errors = n_errors + 1;
            finish_test;
        end
    end
endmodule // tb_priority_interrupt_controller
